// [bench/tb.sv]
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tuc_pkg::*;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic        trig = 1'b0;
   logic [1:0]  smode = 2'h0;
   logic [2:0]  pin = 3'h0;
   logic        oen = 1'b0;
   logic [6:0]  act = 7'h00;
   logic [31:0] rdat, q;
   logic [1:0]  rsp, r;
   logic [6:0]  cout;
   logic        wreq, fti, trg_out, irq;
   logic [7:0]  scnt, n0;
   int          errors = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   always #50 clk = ~clk;
   tuc_timer_ctrl u_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h3),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_avs_response(rsp),
      .i_trig_in(trig), .i_slave_mode(smode), .i_channel_pin(pin),
      .i_main_output_enable(oen), .i_active_out(act), .o_chan_out(cout),
      .o_first_timer_input(fti), .o_trigger_output(trg_out), .o_irq(irq));
   tuc_slave_tmr u_slv (.i_clk_sys(clk), .i_rstn(rstn), .i_trigger(trg_out), .o_count(scnt));
   // ---------------------------------------------------------
   // bus access, compare and closing
   // ---------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd  <= d;
      rd  <= !w;
      wr  <= w;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      r = rsp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(s, e, q);
   endtask
   // pins and outputs pass synchronisers, so let them settle
   task automatic wt();
      repeat (5) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         print_verdict();
      end
   end
   // ---------------------------------------------------------
   // tests
   // ---------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rdc("ctrl1", TUC_OFF_CTRL1, 32'h0);
      rdc("ctrl2", TUC_OFF_CTRL2, 32'h0);
      bus(1'b1, TUC_OFF_CTRL2, 32'hffff);
      rdc("ctrl2", TUC_OFF_CTRL2, 32'h7ff0);
      rdc("evgen", TUC_OFF_EVGEN, 32'h0);
      bus(1'b1, 8'h40, 32'h1);
      chk("resp", 32'h3, {30'h0, r});
      chk("idle", 32'h7f, {25'h0, cout});
      bus(1'b1, TUC_OFF_CTRL2, 32'h2a00);
      wt();
      chk("idle", 32'h2a, {25'h0, cout});
      oen <= 1'b1;
      act <= 7'h55;
      wt();
      chk("active", 32'h55, {25'h0, cout});
      oen <= 1'b0;
      bus(1'b1, TUC_OFF_LOCK, 32'h1);
      bus(1'b1, TUC_OFF_CTRL2, 32'h7f00);
      rdc("locked", TUC_OFF_CTRL2, 32'h2a00);
      $display("test registers done");
      pin <= 3'b011;
      bus(1'b1, TUC_OFF_CTRL2, 32'h0);
      wt();
      chk("ti direct", 32'h1, {31'h0, fti});
      bus(1'b1, TUC_OFF_CTRL2, 32'h80);
      wt();
      chk("ti xor", 32'h0, {31'h0, fti});
      $display("test input select done");
      n0 = scnt;
      bus(1'b1, TUC_OFF_EVGEN, 32'h1);
      wt();
      chk("trig out reset", {24'h0, n0 + 8'h1}, {24'h0, scnt});
      bus(1'b1, TUC_OFF_CTRL2, 32'h20);
      bus(1'b1, TUC_OFF_STAT, 32'h7);
      bus(1'b1, TUC_OFF_MASK, 32'h1);
      bus(1'b1, TUC_OFF_RELOAD, 32'h1234);
      bus(1'b1, TUC_OFF_CTRL1, 32'h2);
      n0 = scnt;
      bus(1'b1, TUC_OFF_EVGEN, 32'h1);
      wt();
      chk("no update", {24'h0, n0}, {24'h0, scnt});
      chk("no irq", 32'h0, {31'h0, irq});
      rdc("reload held", TUC_OFF_RELOAD, 32'hffff);
      bus(1'b1, TUC_OFF_CTRL1, 32'h0);
      bus(1'b1, TUC_OFF_EVGEN, 32'h1);
      wt();
      chk("trig out update", {24'h0, n0 + 8'h1}, {24'h0, scnt});
      chk("irq", 32'h1, {31'h0, irq});
      rdc("reload loaded", TUC_OFF_RELOAD, 32'h1234);
      bus(1'b1, TUC_OFF_STAT, 32'h1);
      chk("irq clr", 32'h0, {31'h0, irq});
      bus(1'b1, TUC_OFF_MASK, 32'h0);
      bus(1'b1, TUC_OFF_EVGEN, 32'h1);
      wt();
      chk("irq mask", 32'h0, {31'h0, irq});
      bus(1'b0, TUC_OFF_STAT, 32'h0);
      chk("status", 32'h1, q & 32'h1);
      $display("test update done");
      bus(1'b1, TUC_OFF_CTRL2, 32'h10);
      bus(1'b1, TUC_OFF_CTRL1, 32'h1);
      wt();
      chk("trig out enable", 32'h1, {31'h0, trg_out});
      bus(1'b1, TUC_OFF_CTRL1, 32'h0);
      wt();
      chk("trig out stop", 32'h0, {31'h0, trg_out});
      smode <= 2'h1;
      trig <= 1'b1;
      wt();
      rdc("auto run", TUC_OFF_CTRL1, 32'h1);
      bus(1'b1, TUC_OFF_CTRL1, 32'h0);
      bus(1'b1, TUC_OFF_CTRL2, 32'h0);
      smode <= 2'h3;
      trig <= 1'b0;
      wt();
      n0 = scnt;
      trig <= 1'b1;
      wt();
      chk("trig out slave rst", {24'h0, n0 + 8'h1}, {24'h0, scnt});
      smode <= 2'h2;
      trig <= 1'b0;
      bus(1'b1, TUC_OFF_CTRL2, 32'h10);
      bus(1'b1, TUC_OFF_CTRL1, 32'h1);
      wt();
      chk("gate closed", 32'h0, {31'h0, trg_out});
      trig <= 1'b1;
      wt();
      chk("gate open", 32'h1, {31'h0, trg_out});
      bus(1'b1, TUC_OFF_CTRL1, 32'h0);
      $display("test master modes done");
      print_verdict();
   end
endmodule
`default_nettype wire

// [bench/tuc_checker.sv]
`default_nettype none
module tuc_chk
   import tuc_pkg::*;
(
   // clock and reset
   input wire logic        i_clk_sys,
   input wire logic        i_rstn,
   // register bus
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic [1:0]  o_avs_response,
   // outputs
   input wire logic        i_main_output_enable,
   input wire logic [6:0]  i_active_out,
   input wire logic [6:0]  o_chan_out,
   input wire logic        o_trigger_output
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   logic       req;
   logic       acc;
   logic       wac;
   logic       lk;
   logic [2:0] msel;
   logic [6:0] idl;
   assign req = i_avs_read | i_avs_write;
   assign acc = req & ~o_avs_waitrequest;
   assign wac = acc & i_avs_write;
   // ---------------------------------------------------------
   // mirror of the written control two fields and lock state
   // ---------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         lk  <= 1'b0;
         msel <= 3'h0;
         idl <= 7'h00;
      end else begin
         if (wac && i_avs_address == TUC_OFF_LOCK && !lk)
            lk <= |i_avs_writedata[1:0];
         if (wac && i_avs_address == TUC_OFF_CTRL2 && i_avs_byteenable[0])
            msel <= i_avs_writedata[6:4];
         if (wac && i_avs_address == TUC_OFF_CTRL2 && i_avs_byteenable[1] && !lk)
            idl <= i_avs_writedata[14:8];
      end
   end
   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   AST_ONE_WAIT: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("more than one wait state");
   AST_UNMAP: assert property (acc && i_avs_address > 8'h24 |->
      o_avs_response == 2'b11 && o_avs_readdata == 32'h0)
      else $error("unmapped access not refused");
   AST_C2_RSVD: assert property (acc && i_avs_read && i_avs_address == TUC_OFF_CTRL2 |->
      o_avs_readdata[31:15] == 17'h0 && o_avs_readdata[3:0] == 4'h0)
      else $error("reserved control two bits read nonzero");
   AST_EVG_RD: assert property (acc && i_avs_read && i_avs_address == TUC_OFF_EVGEN |->
      o_avs_readdata == 32'h0)
      else $error("event register read nonzero");
   AST_IDLE: assert property ((!i_main_output_enable && $stable(idl))[*5] |->
      o_chan_out == idl)
      else $error("idle level not applied");
   AST_ACTIVE: assert property ((i_main_output_enable && $stable(i_active_out))[*5] |->
      o_chan_out == i_active_out)
      else $error("active level not passed");
   AST_PULSE: assert property (msel != 3'h1 && o_trigger_output |=> !o_trigger_output)
      else $error("trigger output not a pulse");
   AST_TRIG_OFF: assert property ((msel == 3'h3 || msel[2])[*3] |-> !o_trigger_output)
      else $error("unused master code drives trigger");
   cover property (wac);
   cover property (o_trigger_output);
   cover property (acc && o_avs_response == 2'b11);
endmodule
bind tuc_timer_ctrl tuc_chk u_chk (.*);
`default_nettype wire

// [bench/tuc_slave_tmr.sv]
`default_nettype none
// slave timer on the system clock: counts rising edges of the master's trigger output
module tuc_slave_tmr (
   input  wire logic i_clk_sys,
   input  wire logic i_rstn,
   input  wire logic i_trigger,
   output logic [7:0] o_count
);
   logic prev;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         prev    <= 1'b0;
         o_count <= 8'h00;
      end else begin
         prev <= i_trigger;
         if (i_trigger && !prev) o_count <= o_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

// [hdl/tuc_pkg.sv]
`default_nettype none
package tuc_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] TUC_OFF_CTRL1 = 8'h00;
   localparam logic [7:0] TUC_OFF_CTRL2 = 8'h04;
   localparam logic [7:0] TUC_OFF_EVGEN = 8'h08;
   localparam logic [7:0] TUC_OFF_LOCK  = 8'h0c;
   localparam logic [7:0] TUC_OFF_STAT  = 8'h10;
   localparam logic [7:0] TUC_OFF_MASK  = 8'h14;
   localparam logic [7:0] TUC_OFF_RELOAD = 8'h18;
   localparam logic [7:0] TUC_OFF_PRESC  = 8'h1c;
   localparam logic [7:0] TUC_OFF_CMP   = 8'h20;
   localparam logic [7:0] TUC_OFF_CNT   = 8'h24;
   // ----------------------------------------------------------------
   // control one fields
   // ----------------------------------------------------------------
   localparam int TUC_C1_RUN    = 0;
   localparam int TUC_C1_UDIS   = 1;
   // ----------------------------------------------------------------
   // control two fields
   // ----------------------------------------------------------------
   localparam int TUC_C2_MSEL_LO = 4;
   localparam int TUC_C2_XOR    = 7;
   localparam int TUC_C2_IDLE_LO = 8;
   localparam int TUC_C2_IDLE_HI = 14;
   localparam logic [15:0] TUC_C2_WMASK = 16'h00f0;
   localparam logic [15:0] TUC_C2_IDLE_MASK = 16'h7f00;
   localparam logic [15:0] TUC_RST_C1 = 16'h0000;
   localparam logic [15:0] TUC_RST_C2 = 16'h0000;
   localparam logic [15:0] TUC_RST_RELOAD = 16'hffff;
   // ----------------------------------------------------------------
   // event generate and status bits
   // ----------------------------------------------------------------
   localparam int TUC_EV_UPDGEN = 0;
   localparam int TUC_ST_UPD    = 0;
   localparam int TUC_ST_TRG    = 1;
   localparam int TUC_ST_RST    = 2;
   localparam int TUC_NSTAT     = 3;
   // ----------------------------------------------------------------
   // master-mode codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TUC_MM_RESET  = 3'b000,
      TUC_MM_ENABLE = 3'b001,
      TUC_MM_UPDATE = 3'b010
   } tuc_mm_e;
   // ----------------------------------------------------------------
   // slave mode requests
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TUC_SM_OFF     = 2'b00,
      TUC_SM_TRIGGER = 2'b01,
      TUC_SM_GATED   = 2'b10,
      TUC_SM_RESET   = 2'b11
   } tuc_sm_e;
endpackage
`default_nettype wire

// [hdl/tuc_timer_ctrl.sv]
`default_nettype none
module tuc_timer_ctrl
   import tuc_pkg::*;
#(
   parameter int CW = 16
) (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rstn,
   // avalon-mm slave
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   output logic [1:0]       o_avs_response,
   // slave-mode controller and pins (asynchronous)
   input  wire logic        i_trig_in,
   input  wire logic [1:0]  i_slave_mode,
   input  wire logic [2:0]  i_channel_pin,
   input  wire logic        i_main_output_enable,
   input  wire logic [6:0]  i_active_out,
   // outputs
   output logic [6:0]       o_chan_out,
   output logic             o_first_timer_input,
   output logic             o_trigger_output,
   output logic             o_irq
);
   import tuc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      // two-stage synchronisers for the trigger, slave mode, pin and output enable inputs
      logic [1:0]  s_trig;
      logic [1:0]  s_mode0;
      logic [1:0]  s_mode1;
      logic [2:0]  s_pin0;
      logic [2:0]  s_pin1;
      logic [1:0]  s_oen;
      logic        trig_d;
      // bus answer
      logic        ack;
      logic [31:0] rdata;
      logic [1:0]  resp;
      // software registers
      logic [15:0] ctrl1;
      logic [15:0] ctrl2;
      logic [1:0]  lock;
      logic [TUC_NSTAT-1:0] stat;
      logic [TUC_NSTAT-1:0] mask;
      // preload copies, written by software
      logic [CW-1:0] reload_pre;
      logic [CW-1:0] presc_pre;
      logic [CW-1:0] cmp_pre;
      // active copies, loaded only by an update event, then the prescale and main counters
      logic [CW-1:0] reload;
      logic [CW-1:0] presc;
      logic [CW-1:0] cmp;
      logic [CW-1:0] pcnt;
      logic [CW-1:0] cnt;
      // registered outputs
      logic        trig_out;
      logic        first_in;
      logic [6:0]  chan;
   } tuc_state_s;

   tuc_state_s st;
   tuc_state_s next_st;

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old_v;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   logic        acc;
   logic        wr;
   logic        trig_rise;
   logic        sm_reset;
   logic        sm_trig;
   logic        gate_ok;
   logic        run;
   logic        tick;
   logic        overflow;
   logic        upd_gen;
   logic        upd;
   logic        reinit;
   logic [15:0] wd16;
   logic [15:0] c2w;

   always_comb begin
      next_st = st;
      c2w     = 16'h0000;
      // ----------------------------------------------------------------
      // input synchronisers: stage one feeds stage two only
      // ----------------------------------------------------------------
      next_st.s_trig  = {st.s_trig[0], i_trig_in};
      next_st.s_mode0 = i_slave_mode;
      next_st.s_mode1 = st.s_mode0;
      next_st.s_pin0  = i_channel_pin;
      next_st.s_pin1  = st.s_pin0;
      next_st.s_oen   = {st.s_oen[0], i_main_output_enable};
      next_st.trig_d  = st.s_trig[1];

      // the edge detector resets to the idle low level of the trigger
      // pin, so the release of reset looks like a rising edge only if the pin is already high
      trig_rise = st.s_trig[1] & ~st.trig_d;
      sm_reset  = trig_rise && (st.s_mode1 == TUC_SM_RESET);
      sm_trig   = trig_rise && (st.s_mode1 == TUC_SM_TRIGGER);
      gate_ok   = (st.s_mode1 != TUC_SM_GATED) | st.s_trig[1];

      // ----------------------------------------------------------------
      // bus decode; one wait cycle, answer on the next edge
      // ----------------------------------------------------------------
      // the ack flop blocks a second take while the master still holds
      // its request during the answer cycle
      acc     = (i_avs_read | i_avs_write) & ~st.ack;
      wr      = acc & i_avs_write;
      wd16    = merge16(16'h0000, i_avs_writedata, i_avs_byteenable);
      upd_gen = wr && (i_avs_address == TUC_OFF_EVGEN) && wd16[TUC_EV_UPDGEN];
      next_st.ack  = acc;
      next_st.resp = 2'b00;

      // ----------------------------------------------------------------
      // counter core; run bit gates every clock source
      // ----------------------------------------------------------------
      run      = st.ctrl1[TUC_C1_RUN] & gate_ok;
      tick     = run && (st.pcnt == st.presc);
      overflow = tick && (st.cnt == st.reload);
      reinit   = upd_gen | sm_reset;
      upd      = ~st.ctrl1[TUC_C1_UDIS] & (overflow | reinit);
      if (reinit) begin
         next_st.pcnt = '0;
         next_st.cnt  = '0;
      end else if (run) begin
         if (tick) begin
            next_st.pcnt = '0;
         end else begin
            next_st.pcnt = st.pcnt + 1'b1;
         end
         if (tick) begin
            if (overflow) begin
               next_st.cnt = '0;
            end else begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
      end
      // with updates disabled the active copies hold, so software may
      // rewrite several preloads and have them all take effect together
      if (upd) begin
         next_st.reload = st.reload_pre;
         next_st.presc  = st.presc_pre;
         next_st.cmp    = st.cmp_pre;
      end
      if (sm_trig) begin
         next_st.ctrl1[TUC_C1_RUN] = 1'b1;
      end

      // ----------------------------------------------------------------
      // register writes
      // ----------------------------------------------------------------
      if (wr) begin
         unique case (i_avs_address)
            TUC_OFF_CTRL1: begin
               next_st.ctrl1 = merge16(st.ctrl1, i_avs_writedata, i_avs_byteenable) &
                               16'h0003;
               if (sm_trig) begin
                  next_st.ctrl1[TUC_C1_RUN] = 1'b1;
               end
            end
            TUC_OFF_CTRL2: begin
               c2w = merge16(st.ctrl2, i_avs_writedata, i_avs_byteenable);
               if (st.lock != 2'b00) begin
                  // idle levels frozen once any lock level is set
                  next_st.ctrl2 = (c2w & TUC_C2_WMASK) |
                                  (st.ctrl2 & TUC_C2_IDLE_MASK);
               end else begin
                  next_st.ctrl2 = (c2w & TUC_C2_WMASK) |
                                  (c2w & TUC_C2_IDLE_MASK);
               end
            end
            TUC_OFF_LOCK: begin
               if (st.lock == 2'b00 && i_avs_byteenable[0]) begin
                  next_st.lock = i_avs_writedata[1:0];
               end
            end
            TUC_OFF_STAT: begin
               if (i_avs_byteenable[0]) begin
                  next_st.stat = st.stat & ~i_avs_writedata[TUC_NSTAT-1:0];
               end
            end
            TUC_OFF_MASK: begin
               if (i_avs_byteenable[0]) begin
                  next_st.mask = i_avs_writedata[TUC_NSTAT-1:0];
               end
            end
            TUC_OFF_RELOAD: begin
               next_st.reload_pre = merge16(st.reload_pre, i_avs_writedata,
                                            i_avs_byteenable);
            end
            TUC_OFF_PRESC: begin
               next_st.presc_pre = merge16(st.presc_pre, i_avs_writedata,
                                           i_avs_byteenable);
            end
            TUC_OFF_CMP: begin
               next_st.cmp_pre = merge16(st.cmp_pre, i_avs_writedata, i_avs_byteenable);
            end
            TUC_OFF_EVGEN: begin
            end
            default: begin
               next_st.resp = 2'b11;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // sticky status: set wins over a same-cycle clear
      // ----------------------------------------------------------------
      next_st.stat[TUC_ST_UPD] = next_st.stat[TUC_ST_UPD] | upd;
      next_st.stat[TUC_ST_TRG] = next_st.stat[TUC_ST_TRG] | sm_trig;
      next_st.stat[TUC_ST_RST] = next_st.stat[TUC_ST_RST] | reinit;

      // ----------------------------------------------------------------
      // reads
      // ----------------------------------------------------------------
      // read data stands for the answer cycle only and is zero otherwise
      next_st.rdata = 32'h0000_0000;
      if (acc && i_avs_read) begin
         unique case (i_avs_address)
            TUC_OFF_CTRL1: begin
               next_st.rdata = {16'h0000, st.ctrl1};
            end
            TUC_OFF_CTRL2: begin
               next_st.rdata = {16'h0000, st.ctrl2};
            end
            TUC_OFF_EVGEN: begin
               next_st.rdata = 32'h0000_0000;
            end
            TUC_OFF_LOCK: begin
               next_st.rdata = {30'h0, st.lock};
            end
            TUC_OFF_STAT: begin
               next_st.rdata = {29'h0, st.stat};
            end
            TUC_OFF_MASK: begin
               next_st.rdata = {29'h0, st.mask};
            end
            // reload and prescale read back the active copy, not the preload
            TUC_OFF_RELOAD: begin
               next_st.rdata = {16'h0000, st.reload};
            end
            TUC_OFF_PRESC: begin
               next_st.rdata = {16'h0000, st.presc};
            end
            TUC_OFF_CMP: begin
               next_st.rdata = {16'h0000, st.cmp};
            end
            TUC_OFF_CNT: begin
               next_st.rdata = {16'h0000, st.cnt};
            end
            default: begin
               next_st.resp = 2'b11;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // trigger output; registered, so a pin-driven reset shows in the same
      // cycle as the counter clear (plus the synchroniser)
      // ----------------------------------------------------------------
      // codes 011 to 111 belong to the compare logic outside this block
      // and drive a quiet low here
      unique case (st.ctrl2[TUC_C2_MSEL_LO +: 3])
         TUC_MM_RESET: begin
            next_st.trig_out = reinit;
         end
         TUC_MM_ENABLE: begin
            next_st.trig_out = run;
         end
         TUC_MM_UPDATE: begin
            next_st.trig_out = upd;
         end
         default: begin
            next_st.trig_out = 1'b0;
         end
      endcase

      // ----------------------------------------------------------------
      // first input select and idle levels
      // ----------------------------------------------------------------
      if (st.ctrl2[TUC_C2_XOR]) begin
         next_st.first_in = ^st.s_pin1;
      end else begin
         next_st.first_in = st.s_pin1[0];
      end
      // dead time itself lives in the generator outside; this picks the level
      if (st.s_oen[1]) begin
         next_st.chan = i_active_out;
      end else begin
         next_st.chan = st.ctrl2[TUC_C2_IDLE_HI:TUC_C2_IDLE_LO];
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st            <= '0;
         st.ctrl1      <= TUC_RST_C1;
         st.ctrl2      <= TUC_RST_C2;
         st.reload_pre <= TUC_RST_RELOAD;
         st.reload     <= TUC_RST_RELOAD;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // waitrequest is combinational so the first wait state is raised in
   // the same cycle as the request
   assign o_avs_waitrequest   = (i_avs_read | i_avs_write) & ~st.ack;
   assign o_avs_readdata      = st.rdata;
   assign o_avs_response      = st.resp;
   assign o_chan_out          = st.chan;
   assign o_first_timer_input = st.first_in;
   assign o_trigger_output    = st.trig_out;
   assign o_irq               = |(st.stat & st.mask);
endmodule
`default_nettype wire
